// ### src/dso_pkg.sv
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package dso_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int SECOND_NS = 1000000000;
	localparam logic [27:0] SEC_CYCLES = 28'(SECOND_NS / CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// Register map, byte addresses
	// ------------------------------------------------------------
	localparam int APB_AW = 12;
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_TIME = 12'h004;
	localparam logic [11:0] REG_IRQ_STS = 12'h008;
	localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
	localparam logic [11:0] REG_STATE = 12'h010;
	localparam logic [11:0] REG_SCHED_BASE = 12'h020;
	localparam logic [11:0] REG_SCHED_END = 12'h050;

	// ------------------------------------------------------------
	// Fields
	// ------------------------------------------------------------
	localparam int NUM_OUT = 3;
	localparam int SLOTS = 4;
	localparam int NUM_SCHED = 12;
	localparam int MODE_W = 2;
	localparam int SS_LSB = 0;
	localparam int MM_LSB = 8;
	localparam int HH_LSB = 16;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_ONCE = 2'h1;
	localparam logic [1:0] MODE_TWICE = 2'h2;
	localparam logic [1:0] MODE_RSVD = 2'h3;
	localparam int SLOT_ON1 = 0;
	localparam int SLOT_OFF1 = 1;
	localparam int SLOT_ON2 = 2;
	localparam int SLOT_OFF2 = 3;
	localparam logic [4:0] HH_MAX = 5'h17;
	localparam logic [5:0] MS_MAX = 6'h3B;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
	} dso_time_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} dso_apb_req_t;

endpackage

// ### src/dso_daily_schedule_outputs.sv
`timescale 1ns/10ps
module dso_daily_schedule_outputs #(
	parameter logic [27:0] SEC_CYCLES = dso_pkg::SEC_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire dso_pkg::dso_apb_req_t apb_req_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic status_output_o,
	output logic switched_output_one_o,
	output logic switched_output_two_o,
	output logic status_indicator_o,
	output logic output_one_indicator_o,
	output logic output_two_indicator_o,
	output logic irq_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0][1:0] mode;
		dso_pkg::dso_time_t [11:0] sched;
		dso_pkg::dso_time_t tod;
		logic [27:0] div;
		logic eval;
		logic [2:0] outs;
		logic [2:0] sts;
		logic [2:0] mask;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
	} dso_state_t;

	dso_state_t s_r;
	dso_state_t s_nxt;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic dso_pkg::dso_time_t t_unpack(input logic [31:0] w);
		dso_pkg::dso_time_t t;
		t.hh = w[dso_pkg::HH_LSB +: 5];
		t.mm = w[dso_pkg::MM_LSB +: 6];
		t.ss = w[dso_pkg::SS_LSB +: 6];
		return t;
	endfunction

	function automatic logic [31:0] t_pack(input dso_pkg::dso_time_t t);
		logic [31:0] w;
		w = 32'h0;
		w[dso_pkg::HH_LSB +: 5] = t.hh;
		w[dso_pkg::MM_LSB +: 6] = t.mm;
		w[dso_pkg::SS_LSB +: 6] = t.ss;
		return w;
	endfunction

	// Fields in range, other bits zero
	function automatic logic t_valid(input logic [31:0] w);
		dso_pkg::dso_time_t t;
		t = t_unpack(w);
		return (t_pack(t) == w) && (t.hh <= dso_pkg::HH_MAX) &&
			(t.mm <= dso_pkg::MS_MAX) && (t.ss <= dso_pkg::MS_MAX);
	endfunction

	// One second on, wrapping at midnight
	function automatic dso_pkg::dso_time_t t_next(input dso_pkg::dso_time_t t);
		dso_pkg::dso_time_t n;
		n = t;
		if (t.ss == dso_pkg::MS_MAX) begin
			n.ss = 6'h00;
			if (t.mm == dso_pkg::MS_MAX) begin
				n.mm = 6'h00;
				n.hh = (t.hh == dso_pkg::HH_MAX) ? 5'h00 : t.hh + 5'h01;
			end else begin
				n.mm = t.mm + 6'h01;
			end
		end else begin
			n.ss = t.ss + 6'h01;
		end
		return n;
	endfunction

	function automatic logic sched_hit(input logic [11:0] a);
		return (a >= dso_pkg::REG_SCHED_BASE) &&
			(a < dso_pkg::REG_SCHED_END) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [3:0] sched_idx(input logic [11:0] a);
		logic [11:0] d;
		d = a - dso_pkg::REG_SCHED_BASE;
		return d[5:2];
	endfunction

	// Slot k of output o
	function automatic int slot(input int o, input int k);
		return o * dso_pkg::SLOTS + k;
	endfunction

	// Error answer for an access
	function automatic logic apb_err(input dso_pkg::dso_apb_req_t q);
		logic e;
		e = 1'b0;
		if (sched_hit(q.paddr)) begin
			e = q.pwrite && !t_valid(q.pwdata);
		end else begin
			case (q.paddr)
				dso_pkg::REG_CTRL: begin
					e = q.pwrite && ((q.pwdata[31:6] != 26'h0) ||
						(q.pwdata[1:0] == dso_pkg::MODE_RSVD) ||
						(q.pwdata[3:2] == dso_pkg::MODE_RSVD) ||
						(q.pwdata[5:4] == dso_pkg::MODE_RSVD));
				end
				dso_pkg::REG_TIME: begin
					e = q.pwrite && !t_valid(q.pwdata);
				end
				dso_pkg::REG_IRQ_MASK: begin
					e = 1'b0;
				end
				dso_pkg::REG_IRQ_STS, dso_pkg::REG_STATE: begin
					e = q.pwrite;
				end
				default: begin
					e = 1'b1;
				end
			endcase
		end
		return e;
	endfunction

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic on_hit;
		logic off_hit;
		logic access;
		logic done;
		logic [2:0] clr;
		dso_pkg::dso_time_t t;
		on_hit = 1'b0;
		off_hit = 1'b0;
		clr = 3'h0;
		t = s_r.tod;
		access = apb_req_i.psel && apb_req_i.penable;
		done = access && s_r.pready;
		s_nxt = s_r;

		// Seconds divider and time of day
		s_nxt.eval = 1'b0;
		if (s_r.div == SEC_CYCLES - 28'h1) begin
			s_nxt.div = 28'h0;
			s_nxt.tod = t_next(s_r.tod);
			s_nxt.eval = 1'b1;
		end else begin
			s_nxt.div = s_r.div + 28'h1;
		end

		// Compare time of day with each active slot
		for (int o = 0; o < dso_pkg::NUM_OUT; o++) begin
			on_hit = (t == s_r.sched[slot(o, dso_pkg::SLOT_ON1)]);
			off_hit = (t == s_r.sched[slot(o, dso_pkg::SLOT_OFF1)]);
			if (s_r.mode[o] == dso_pkg::MODE_TWICE) begin
				on_hit = on_hit ||
					(t == s_r.sched[slot(o, dso_pkg::SLOT_ON2)]);
				off_hit = off_hit ||
					(t == s_r.sched[slot(o, dso_pkg::SLOT_OFF2)]);
			end
			if (s_r.mode[o] == dso_pkg::MODE_OFF) begin
				s_nxt.outs[o] = 1'b0;
			end else if (s_r.eval && off_hit) begin
				s_nxt.outs[o] = 1'b0;
			end else if (s_r.eval && on_hit) begin
				s_nxt.outs[o] = 1'b1;
			end
		end

		// APB: one wait state, then completion
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.prdata = 32'h0;
		if (access && !s_r.pready) begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = apb_err(apb_req_i);
			if (!apb_req_i.pwrite && sched_hit(apb_req_i.paddr)) begin
				s_nxt.prdata = t_pack(s_r.sched[sched_idx(apb_req_i.paddr)]);
			end else if (!apb_req_i.pwrite) begin
				case (apb_req_i.paddr)
					dso_pkg::REG_CTRL: begin
						s_nxt.prdata = {26'h0, s_r.mode};
					end
					dso_pkg::REG_TIME: begin
						s_nxt.prdata = t_pack(s_r.tod);
					end
					dso_pkg::REG_IRQ_STS: begin
						s_nxt.prdata = {29'h0, s_r.sts};
					end
					dso_pkg::REG_IRQ_MASK: begin
						s_nxt.prdata = {29'h0, s_r.mask};
					end
					dso_pkg::REG_STATE: begin
						s_nxt.prdata = {29'h0, s_r.outs};
					end
					default: begin
						s_nxt.prdata = 32'h0;
					end
				endcase
			end
		end

		// Writes and read side effects at completion
		if (done && apb_req_i.pwrite && !s_r.pslverr) begin
			if (sched_hit(apb_req_i.paddr)) begin
				s_nxt.sched[sched_idx(apb_req_i.paddr)] =
					t_unpack(apb_req_i.pwdata);
			end else begin
				case (apb_req_i.paddr)
					dso_pkg::REG_CTRL: begin
						s_nxt.mode = apb_req_i.pwdata[5:0];
					end
					dso_pkg::REG_TIME: begin
						s_nxt.tod = t_unpack(apb_req_i.pwdata);
						s_nxt.div = 28'h0;
						s_nxt.eval = 1'b1;
					end
					dso_pkg::REG_IRQ_MASK: begin
						s_nxt.mask = apb_req_i.pwdata[2:0];
					end
					default: begin
						s_nxt.mask = s_r.mask;
					end
				endcase
			end
		end
		if (done && !apb_req_i.pwrite &&
			apb_req_i.paddr == dso_pkg::REG_IRQ_STS) begin
			clr = s_r.prdata[2:0];
		end

		// Sticky change events, set wins over clear
		s_nxt.sts = (s_r.sts & ~clr) | (s_nxt.outs ^ s_r.outs);
		s_nxt.irq = |(s_nxt.sts & s_nxt.mask);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs and panel indicators
	assign prdata_o = s_r.prdata;
	assign pready_o = s_r.pready;
	assign pslverr_o = s_r.pslverr;
	assign status_output_o = s_r.outs[0];
	assign switched_output_one_o = s_r.outs[1];
	assign switched_output_two_o = s_r.outs[2];
	assign status_indicator_o = s_r.outs[0];
	assign output_one_indicator_o = s_r.outs[1];
	assign output_two_indicator_o = s_r.outs[2];
	assign irq_o = s_r.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	mode_legal_a: assert property (
		s_r.mode[0] != dso_pkg::MODE_RSVD &&
		s_r.mode[1] != dso_pkg::MODE_RSVD &&
		s_r.mode[2] != dso_pkg::MODE_RSVD)
		else $error("illegal output mode stored");

	twice_second_a: assert property (
		s_r.eval && s_r.mode[1] == dso_pkg::MODE_TWICE &&
		s_r.tod == s_r.sched[6] && s_r.tod != s_r.sched[5] &&
		s_r.tod != s_r.sched[7] |=> switched_output_one_o)
		else $error("second on time did not close output one");

	once_skip_a: assert property (
		s_r.eval && s_r.mode[0] == dso_pkg::MODE_ONCE &&
		s_r.tod != s_r.sched[0] && s_r.tod != s_r.sched[1]
		|=> $stable(status_output_o))
		else $error("second pair acted in once mode");

	ctrl_keeps_a: assert property (
		apb_req_i.psel && apb_req_i.penable && s_r.pready &&
		apb_req_i.pwrite && apb_req_i.paddr == dso_pkg::REG_CTRL
		|=> $stable(s_r.sched))
		else $error("mode write altered stored times");

	disabled_open_a: assert property (
		s_r.mode[1] == dso_pkg::MODE_OFF |=> !switched_output_one_o)
		else $error("disabled output one not open");

	tod_range_a: assert property (
		s_r.tod.hh <= dso_pkg::HH_MAX && s_r.tod.mm <= dso_pkg::MS_MAX &&
		s_r.tod.ss <= dso_pkg::MS_MAX)
		else $error("time of day out of range");

	out1_close_a: assert property (
		s_r.eval && s_r.mode[1] != dso_pkg::MODE_OFF &&
		s_r.tod == s_r.sched[4] && s_r.tod != s_r.sched[5] &&
		(s_r.mode[1] != dso_pkg::MODE_TWICE || s_r.tod != s_r.sched[7])
		|=> switched_output_one_o)
		else $error("output one missed its on time");

	out2_open_a: assert property (
		s_r.eval && s_r.mode[2] != dso_pkg::MODE_OFF &&
		s_r.tod == s_r.sched[9] |=> !switched_output_two_o)
		else $error("output two missed its off time");

	ind_one_a: assert property (
		output_one_indicator_o == switched_output_one_o)
		else $error("indicator one differs from output");

	ind_two_a: assert property (
		output_two_indicator_o == switched_output_two_o)
		else $error("indicator two differs from output");

	status_second_a: assert property (
		s_r.eval && s_r.mode[0] == dso_pkg::MODE_TWICE &&
		s_r.tod == s_r.sched[2] && s_r.tod != s_r.sched[1] &&
		s_r.tod != s_r.sched[3] |=> status_output_o)
		else $error("status missed second on time");

	status_ind_a: assert property (
		status_indicator_o == status_output_o)
		else $error("status indicator differs from output");

	hold_state_a: assert property (
		!s_r.eval && s_r.mode[2] != dso_pkg::MODE_OFF
		|=> $stable(switched_output_two_o))
		else $error("output two changed without a match");

	irq_level_a: assert property (
		irq_o == |(s_r.sts & s_r.mask))
		else $error("interrupt level wrong");

	apb_wait_a: assert property (
		apb_req_i.psel && apb_req_i.penable && !pready_o |=> pready_o)
		else $error("access not answered after one wait");

endmodule

// ### tb/dso_load_model.sv
`timescale 1ns/10ps
module dso_load_model (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic [2:0] closed_i,
	output logic [7:0] n_close_o
);
	// ------------------------------------------------
	// Load on output one, counting its closures
	// ------------------------------------------------
	logic [2:0] prev_r;

	// Rising contact state means a fresh closure
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_r <= 3'h0;
			n_close_o <= 8'h00;
		end else begin
			prev_r <= closed_i;
			if (closed_i[1] && !prev_r[1]) begin
				n_close_o <= n_close_o + 8'h01;
			end
		end
	end
endmodule

// ### tb/test_daily_schedule_outputs.sv
`timescale 1ns/10ps
module test_daily_schedule_outputs;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [2:0] x;
	} dso_row_t;
	localparam logic [11:0] T = dso_pkg::REG_TIME;
	localparam logic [11:0] C = dso_pkg::REG_CTRL;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	dso_pkg::dso_apb_req_t rq = '0;
	logic [31:0] prdata_o;
	logic [31:0] q;
	logic pready_o, pslverr_o, irq_o, e;
	wire logic [2:0] o;
	wire logic [2:0] ind;
	logic [7:0] n_close;
	dso_row_t rows [9];
	int n_fail = 0;
	int checked = 0;
	int k;

	// Clock
	always #2 clk_sys_i = ~clk_sys_i;

	dso_daily_schedule_outputs #(.SEC_CYCLES(28'h0000008))
	dso_daily_schedule_outputs_i (
		.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .apb_req_i(rq),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.status_output_o(o[0]), .switched_output_one_o(o[1]),
		.switched_output_two_o(o[2]), .status_indicator_o(ind[0]),
		.output_one_indicator_o(ind[1]), .output_two_indicator_o(ind[2]),
		.irq_o(irq_o));

	dso_load_model dso_load_model_i (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .closed_i(o), .n_close_o(n_close));

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_w(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		checked++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, x, g);
		end
	endtask

	task automatic chk_b(input string nm, input logic x, input logic g);
		checked++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH %s exp %b got %b", nm, x, g);
		end
	endtask

	task automatic chk_o(input logic [2:0] x);
		chk_w("outputs", {29'h0, x}, {29'h0, o});
		chk_w("lamps", {29'h0, x}, {29'h0, ind});
	endtask

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		rq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_sys_i);
		rq.penable <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
		// Answer taken at the completing edge, then released
		q = prdata_o;
		e = pslverr_o;
		rq <= '0;
	endtask

	// Eval cycle, then output update
	task automatic settle;
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask

	// ------------------------------------------------
	// Sequence
	// ------------------------------------------------
	initial begin
		rows = '{'{T, 32'h0000000A, 3'h7}, '{T, 32'h0000000F, 3'h7},
			'{C, 32'h00000021, 3'h5}, '{C, 32'h00000029, 3'h5},
			'{T, 32'h00000014, 3'h0}, '{T, 32'h0000001E, 3'h6},
			'{C, 32'h0000002A, 3'h6}, '{T, 32'h0000001E, 3'h7},
			'{T, 32'h00000028, 3'h0}};
		repeat (12) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(negedge clk_sys_i);
		chk_o(3'h0);
		// Slots 10, 20, 30, 40 s for on1, off1, on2, off2
		for (int i = 0; i < 12; i++) begin
			apb(1'b1, dso_pkg::REG_SCHED_BASE + 12'(4 * i),
				32'((i % 4 + 1) * 10));
		end
		apb(1'b1, C, 32'h00000029);
		// Time jumps and mode changes
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			settle();
			chk_o(rows[i].x);
		end
		apb(1'b0, 12'h030, 32'h0);
		chk_w("slot", 32'h0000000A, q);
		// Natural seconds tick from 9 to 10
		apb(1'b1, T, 32'h00000009);
		for (k = 0; k < 40 && o[1] !== 1'b1; k++) begin
			@(posedge clk_sys_i);
		end
		// A tick that never closes output one ends the run
		if (o[1] !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
		chk_o(3'h7);
		apb(1'b0, dso_pkg::REG_STATE, 32'h0);
		chk_w("state", 32'h00000007, q);
		chk_w("closures", 32'h00000003, {24'h0, n_close});
		// Interrupt masked, unmasked, cleared
		chk_b("irq", 1'b0, irq_o);
		apb(1'b1, dso_pkg::REG_IRQ_MASK, 32'h00000007);
		settle();
		chk_b("irq", 1'b1, irq_o);
		apb(1'b0, dso_pkg::REG_IRQ_STS, 32'h0);
		chk_w("sts", 32'h00000007, q);
		settle();
		chk_b("irq", 1'b0, irq_o);
		// Field limits and unmapped place
		apb(1'b1, 12'h04C, 32'h00173B3B);
		chk_b("err", 1'b0, e);
		apb(1'b1, 12'h04C, 32'h00180000);
		chk_b("err", 1'b1, e);
		apb(1'b0, 12'h04C, 32'h0);
		chk_w("slot", 32'h00173B3B, q);
		apb(1'b0, 12'h100, 32'h0);
		chk_b("err", 1'b1, e);
		chk_w("unmapped", 32'h0, q);
		// Reserved mode refused, stored modes kept
		apb(1'b1, C, 32'h0000002B);
		chk_b("err", 1'b1, e);
		apb(1'b0, C, 32'h0);
		chk_w("ctrl", 32'h0000002A, q);
		// Second reset in mid-run
		@(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk_o(3'h0);
		@(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		apb(1'b0, C, 32'h0);
		chk_w("ctrl", 32'h0, q);
		give_verdict();
	end
endmodule
